// File: design/ebsp_sync.sv
// two-flop synchroniser bank for pin inputs
`default_nettype none
module ebsp_sync #(
    parameter int W = 9
) (
    input wire logic sys_clk,
    input wire logic reset,
    ebsp_pin_if.syncer pins
);
    logic [W-1:0] stage1_q;
    logic [W-1:0] stage2_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1_q <= '1;
            stage2_q <= '1;
        end else begin
            stage1_q <= pins.raw;
            stage2_q <= stage1_q;
        end
    end

    assign pins.synced = stage2_q;
endmodule // ebsp_sync
`default_nettype wire

// File: design/ebsp_top.sv
// external bus control and segment port block
`default_nettype none
//
// Contract
// [RULE1] eight segment lines, each with its own direction bit
// [RULE2] a line set as input has its driver off; code drives all lines with the external bus on, and CAN transmit lines
// [RULE3] input threshold selectable between TTL and CMOS
// [RULE4] only upper four lines may be open-drain, per line
// [RULE5] external bus drives lines with address bits 16 to 23
// [RULE6] first CAN receive on sixth line, transmit on seventh
// [RULE7] second CAN receive on fifth/sixth, transmit on seventh/eighth
// [RULE8] read strobe low for every fetch or data read
// [RULE9] plain style: write strobe low on every data write
// [RULE10] low-byte style: strobe only low-byte writes, all on 8-bit bus
// [RULE11] style chosen by a bit of the config register
// [RULE12] software picks the active level of the ready input
// [RULE13] inactive ready extends access with wait cycles
// [RULE14] address latch pulse commands the address capture
// [RULE15] pin levels sampled every cycle whatever the direction
// [RULE16] writes hit the latch; reads give pin or latch by direction
// [RULE17] ready sampled on the clock; access ends once active seen
// [RULE18] segment address stable from address phase to strobe end
module ebsp_top
    import ebsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    input wire logic accReq,
    input wire logic accWrite,
    input wire logic accLowByte,
    input wire logic [23:0] accAddr,
    output logic accBusy,
    output logic accDone,
    input wire logic [7:0] segIn,
    output logic [7:0] segOut,
    output logic [7:0] segOe,
    output logic thresholdCmos,
    input wire logic readyPin,
    output logic readStrobeN,
    output logic lowByteStoreStrobeN,
    output logic aleOut,
    input wire logic firstCanTransmit,
    input wire logic secondCanTransmit,
    output logic firstCanReceive,
    output logic secondCanReceive
);
    // ---------------------------------------------------------------
    // pin synchroniser
    // ---------------------------------------------------------------
    ebsp_pin_if #(.W(9)) pinIf ();
    assign pinIf.raw = {readyPin, segIn};
    ebsp_sync #(.W(9)) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pins(pinIf)
    );
    wire logic [7:0] pinSample = pinIf.synced[7:0]; // [RULE15]
    wire logic readySync = pinIf.synced[8]; // [RULE17]

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] latch_q;
    logic [7:0] dir_q;
    logic [7:0] odrain_q;
    logic [EBSP_CFG_W-1:0] cfg_q;
    logic [15:0] rdata_q;

    wire logic wrLatch = regWrite && (regAddr == EBSP_OFF_LATCH);
    wire logic wrDir = regWrite && (regAddr == EBSP_OFF_DIR);
    wire logic wrOdrain = regWrite && (regAddr == EBSP_OFF_ODRAIN);
    wire logic strobe_style_select = regWrite && (regAddr == EBSP_OFF_CFG);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            latch_q <= EBSP_RST_LATCH;
            dir_q <= EBSP_RST_DIR;
            odrain_q <= EBSP_RST_ODRAIN;
            cfg_q <= EBSP_RST_CFG;
        end else begin
            if (wrLatch) latch_q <= regWdata[7:0]; // [RULE16]
            if (wrDir) dir_q <= regWdata[7:0]; // [RULE1]
            if (wrOdrain) begin
                odrain_q <= regWdata[7:0] & EBSP_ODRAIN_MASK; // [RULE4]
            end
            if (strobe_style_select) cfg_q <= regWdata[EBSP_CFG_W-1:0]; // [RULE11]
        end
    end

    wire logic cfgCmos = cfg_q[EBSP_CFG_CMOS];
    wire logic cfgStyle = cfg_q[EBSP_CFG_STYLE];
    wire logic cfgRdyEn = cfg_q[EBSP_CFG_RDYEN];
    wire logic cfgRdyPol = cfg_q[EBSP_CFG_RDYPOL];
    wire logic cfgExt = cfg_q[EBSP_CFG_EXTBUS];
    wire logic cfgBus8 = cfg_q[EBSP_CFG_BUS8];
    wire logic cfgCan1 = cfg_q[EBSP_CFG_CAN1];
    wire logic cfgCan2 = cfg_q[EBSP_CFG_CAN2];
    wire logic cfgCan2Sel = cfg_q[EBSP_CFG_CAN2SEL];

    // ---------------------------------------------------------------
    // access sequencer
    // ---------------------------------------------------------------
    ebsp_state_e state_q;
    ebsp_state_e state_d;
    logic [23:0] addr_q;
    logic write_q;
    logic lowByte_q;

    wire logic accTake = accReq && (state_q == EBSP_IDLE);
    // ready seen at the programmed active level
    wire logic readyActive = (readySync == cfgRdyPol); // [RULE12]
    wire logic strobeEnd = !cfgRdyEn || readyActive; // [RULE13] [RULE17]

    always_comb begin
        state_d = state_q;
        case (state_q)
            EBSP_IDLE: begin
                if (accReq) state_d = EBSP_ADDR;
            end
            EBSP_ADDR: begin
                state_d = EBSP_STROBE;
            end
            EBSP_STROBE: begin
                if (strobeEnd) state_d = EBSP_HOLD; // [RULE13]
            end
            EBSP_HOLD: begin
                state_d = EBSP_IDLE;
            end
            default: begin
                state_d = EBSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= EBSP_IDLE;
            addr_q <= EBSP_RST_ADDR;
            write_q <= 1'b0;
            lowByte_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (accTake) begin
                addr_q <= accAddr; // [RULE18]
                write_q <= accWrite;
                lowByte_q <= accLowByte;
            end
        end
    end

    // strobe pins from the next state so they align with it
    wire logic nextStrobe = (state_d == EBSP_STROBE);
    wire logic writeNext = accTake ? accWrite : write_q;
    wire logic lowNext = accTake ? accLowByte : lowByte_q;
    // low-byte style skips high-byte-only writes on a 16-bit bus
    wire logic storeNext = !cfgStyle || cfgBus8 || lowNext; // [RULE10]
    wire logic rdND = !(nextStrobe && !writeNext); // [RULE8]
    wire logic wrND = // [RULE9] [RULE10]
        !(nextStrobe && writeNext && storeNext);
    wire logic aleD = (state_d == EBSP_ADDR); // [RULE14]
    wire logic doneD = (state_d == EBSP_HOLD);
    wire logic busyD = (state_d != EBSP_IDLE);

    // ---------------------------------------------------------------
    // segment port drive
    // ---------------------------------------------------------------
    wire logic can2Tx7 = cfgCan2 && cfgCan2Sel;
    wire logic can2Tx6 = cfgCan2 && !cfgCan2Sel && !cfgCan1;
    logic [7:0] altEn;
    logic [7:0] altVal;
    always_comb begin
        altEn = '0;
        altVal = '0;
        altEn[EBSP_PIN_C1TX] = cfgCan1 || can2Tx6; // [RULE6] [RULE7]
        altVal[EBSP_PIN_C1TX] = cfgCan1 ? firstCanTransmit
                                        : secondCanTransmit;
        altEn[EBSP_PIN_C2TXB] = can2Tx7; // [RULE7]
        altVal[EBSP_PIN_C2TXB] = secondCanTransmit;
    end

    wire logic [7:0] portVal = (altEn & altVal) | (~altEn & latch_q);
    // address already on the lines in the latch pulse cycle
    wire logic [23:0] addrNext = accTake ? accAddr : addr_q; // [RULE14]
    wire logic [7:0] segAddr = addrNext[EBSP_SEG_LSB +: 8]; // [RULE5]
    wire logic [7:0] segOutD = cfgExt ? segAddr : portVal;
    // without the external bus inputs float, outputs drive, alternates take their line; with it all lines drive
    wire logic [7:0] baseOe = // [RULE2]
        cfgExt ? EBSP_ALL_DRIVE : (dir_q | altEn);
    wire logic [7:0] odEff = cfgExt ? 8'h00 : odrain_q;
    // outside external bus mode, open-drain lines release the pin instead of driving high
    wire logic [7:0] segOeD = baseOe & ~(odEff & segOutD); // [RULE4]
    wire logic c1RxD = pinSample[EBSP_PIN_C1RX]; // [RULE6]
    wire logic c2RxD = cfgCan2Sel ? pinSample[EBSP_PIN_C2RXB]
                                  : pinSample[EBSP_PIN_C2RXA]; // [RULE7]

    // ---------------------------------------------------------------
    // register read
    // ---------------------------------------------------------------
    // input lines show the pin, output lines the latch
    wire logic [7:0] latchRead = // [RULE16]
        (dir_q & latch_q) | (~dir_q & pinSample);
    wire logic [15:0] statusRead = {6'h00, readyActive,
                                    (state_q != EBSP_IDLE), pinSample};
    logic [15:0] readMux;
    always_comb begin
        case (regAddr)
            EBSP_OFF_LATCH: readMux = {8'h00, latchRead};
            EBSP_OFF_DIR: readMux = {8'h00, dir_q};
            EBSP_OFF_ODRAIN: readMux = {8'h00, odrain_q};
            EBSP_OFF_CFG: readMux = {7'h00, cfg_q};
            EBSP_OFF_STATUS: readMux = statusRead;
            default: readMux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) rdata_q <= 16'h0000;
        else rdata_q <= regRead ? readMux : 16'h0000;
    end

    // ---------------------------------------------------------------
    // output flops
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            readStrobeN <= 1'b1;
            lowByteStoreStrobeN <= 1'b1;
            aleOut <= 1'b0;
            accDone <= 1'b0;
            accBusy <= 1'b0;
        end else begin
            readStrobeN <= rdND;
            lowByteStoreStrobeN <= wrND;
            aleOut <= aleD;
            accDone <= doneD;
            accBusy <= busyD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            segOut <= 8'h00;
            segOe <= 8'h00;
            thresholdCmos <= 1'b0;
            firstCanReceive <= 1'b1;
            secondCanReceive <= 1'b1;
        end else begin
            segOut <= segOutD;
            segOe <= segOeD;
            thresholdCmos <= cfgCmos; // [RULE3]
            firstCanReceive <= c1RxD;
            secondCanReceive <= c2RxD;
        end
    end

    assign regRdata = rdata_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_readTaken;
        accTake && !accWrite;
    endsequence
    sequence s_writeTaken;
        accTake && accWrite;
    endsequence

    property p_inputHiz;
        !cfgExt && !cfgCan1 && !cfgCan2
            |=> ((segOe & ~$past(dir_q)) == 8'h00);
    endproperty
    a_inputHiz: assert property (p_inputHiz) // [RULE2]
        else $error("input line driven");

    property p_lowNibblePushPull;
        !cfgExt && !cfgCan1 && !cfgCan2 |=> (segOe[3:0] == $past(dir_q[3:0]));
    endproperty
    a_lowNibblePushPull: assert property (p_lowNibblePushPull) // [RULE4]
        else $error("lower line not push-pull");

    property p_segAddr;
        cfgExt && (state_q != EBSP_IDLE) |=> (segOut == $past(addr_q[23:16]));
    endproperty
    a_segAddr: assert property (p_segAddr) // [RULE5]
        else $error("segment address wrong");

    property p_readStrobe;
        s_readTaken |=> ##1 !readStrobeN && lowByteStoreStrobeN;
    endproperty
    a_readStrobe: assert property (p_readStrobe) // [RULE8]
        else $error("read strobe missing");

    property p_writeStrobe;
        (s_writeTaken and !cfgStyle)
            |=> ##1 !lowByteStoreStrobeN && readStrobeN;
    endproperty
    a_writeStrobe: assert property (p_writeStrobe) // [RULE9]
        else $error("write strobe missing");

    property p_highByteSkip;
        (s_writeTaken and (cfgStyle && !cfgBus8 && !accLowByte))
            |=> lowByteStoreStrobeN [*3];
    endproperty
    a_highByteSkip: assert property (p_highByteSkip) // [RULE10]
        else $error("strobe on high byte");

    property p_waitState;
        (state_q == EBSP_STROBE) && cfgRdyEn && !readyActive
            |=> (state_q == EBSP_STROBE) && !accDone;
    endproperty
    a_waitState: assert property (p_waitState) // [RULE13]
        else $error("wait state skipped");

    property p_alePulse;
        accTake |=> aleOut ##1 !aleOut;
    endproperty
    a_alePulse: assert property (p_alePulse) // [RULE14]
        else $error("address latch pulse wrong");

    property p_aleAddr;
        accTake && cfgExt |=> aleOut && (segOut == $past(accAddr[23:16]));
    endproperty
    a_aleAddr: assert property (p_aleAddr) // [RULE14]
        else $error("address missing at latch pulse");

    property p_addrStable;
        (state_q != EBSP_IDLE) && ($past(state_q) != EBSP_IDLE)
            |-> $stable(addr_q);
    endproperty
    a_addrStable: assert property (p_addrStable) // [RULE18]
        else $error("address moved");

    property p_can1Tx;
        cfgCan1 && !cfgExt |=> segOe[EBSP_PIN_C1TX]
            && (segOut[EBSP_PIN_C1TX] == $past(firstCanTransmit));
    endproperty
    a_can1Tx: assert property (p_can1Tx) // [RULE6]
        else $error("first can transmit lost");
endmodule // ebsp_top
`default_nettype wire

// File: include/ebsp_pin_if.sv
// raw and synchronised pin levels between top and synchroniser
`default_nettype none
interface ebsp_pin_if #(parameter int W = 9);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport syncer(input raw, output synced);
    modport user(output raw, input synced);
endinterface
`default_nettype wire

// File: include/ebsp_pkg.sv
// constants and types of the external bus segment port
`default_nettype none
package ebsp_pkg;
    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------
    localparam int EBSP_ADDR_W = 4;
    localparam int EBSP_DATA_W = 16;
    localparam logic [3:0] EBSP_OFF_LATCH = 4'h0;
    localparam logic [3:0] EBSP_OFF_DIR = 4'h1;
    localparam logic [3:0] EBSP_OFF_ODRAIN = 4'h2;
    localparam logic [3:0] EBSP_OFF_CFG = 4'h3;
    localparam logic [3:0] EBSP_OFF_STATUS = 4'h4;
    // ---------------------------------------------------------------
    // system_config_register fields
    // ---------------------------------------------------------------
    localparam int EBSP_CFG_W = 9;
    localparam int EBSP_CFG_CMOS = 0;
    localparam int EBSP_CFG_STYLE = 1;
    localparam int EBSP_CFG_RDYEN = 2;
    localparam int EBSP_CFG_RDYPOL = 3;
    localparam int EBSP_CFG_EXTBUS = 4;
    localparam int EBSP_CFG_BUS8 = 5;
    localparam int EBSP_CFG_CAN1 = 6;
    localparam int EBSP_CFG_CAN2 = 7;
    localparam int EBSP_CFG_CAN2SEL = 8;
    // status fields
    localparam int EBSP_STAT_BUSY = 8;
    localparam int EBSP_STAT_RDY = 9;
    // ---------------------------------------------------------------
    // reset values and masks
    // ---------------------------------------------------------------
    localparam logic [7:0] EBSP_RST_LATCH = 8'h00;
    localparam logic [7:0] EBSP_RST_DIR = 8'h00;
    localparam logic [7:0] EBSP_RST_ODRAIN = 8'h00;
    localparam logic [8:0] EBSP_RST_CFG = 9'h000;
    localparam logic [7:0] EBSP_ODRAIN_MASK = 8'hF0;
    localparam logic [7:0] EBSP_ALL_DRIVE = 8'hFF;
    localparam logic [23:0] EBSP_RST_ADDR = 24'h00_0000;
    // ---------------------------------------------------------------
    // line positions
    // ---------------------------------------------------------------
    localparam int EBSP_SEG_LSB = 16;
    localparam int EBSP_PIN_C1RX = 5;
    localparam int EBSP_PIN_C1TX = 6;
    localparam int EBSP_PIN_C2RXA = 4;
    localparam int EBSP_PIN_C2RXB = 5;
    localparam int EBSP_PIN_C2TXA = 6;
    localparam int EBSP_PIN_C2TXB = 7;
    // ---------------------------------------------------------------
    // access sequencer
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        EBSP_IDLE = 2'b00,
        EBSP_ADDR = 2'b01,
        EBSP_STROBE = 2'b11,
        EBSP_HOLD = 2'b10
    } ebsp_state_e;
endpackage
`default_nettype wire

// File: sim/ebsp_mem_model.sv
// external memory model: address capture and ready answer
`default_nettype none
module ebsp_mem_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic aleOut,
    input wire logic readStrobeN,
    input wire logic lowByteStoreStrobeN,
    input wire logic [7:0] segOut,
    input wire logic [7:0] waitCycles,
    input wire logic activeLevel,
    output logic readyPin,
    output logic [7:0] latchedSeg,
    output logic stableFault
);
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------------
    // strobe tracking
    // ---------------------------------------------------------------
    logic [7:0] strobeCnt;
    logic strobeOn;
    assign strobeOn = !readStrobeN || !lowByteStoreStrobeN;
    // ---------------------------------------------------------------
    // capture, stability watch and ready answer
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            strobeCnt <= 8'h00;
            readyPin <= ~activeLevel;
            latchedSeg <= 8'h00;
            stableFault <= 1'b0;
        end else begin
            if (aleOut) begin
                latchedSeg <= segOut;
            end
            if (strobeOn && segOut != latchedSeg) begin
                stableFault <= 1'b1;
            end
            strobeCnt <= strobeOn ? strobeCnt + 8'h01 : 8'h00;
            // inactive level stretches the access until count reached
            if (strobeOn && strobeCnt + 8'h01 >= waitCycles) begin
                readyPin <= activeLevel;
            end else begin
                readyPin <= ~activeLevel;
            end
        end
    end
endmodule // ebsp_mem_model
`default_nettype wire

// File: sim/ebsp_top_tb.sv
// self-checking testbench of the external bus segment port
`default_nettype none
module ebsp_top_tb;
    import ebsp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic sys_clk, reset, regWrite, regRead, accReq, accWrite, accLowByte;
    logic [3:0] regAddr;
    logic [15:0] regWdata, regRdata, d;
    logic [23:0] accAddr;
    logic accBusy, accDone, thresholdCmos, readyPin, readStrobeN;
    logic lowByteStoreStrobeN, aleOut, firstCanTransmit, secondCanTransmit;
    logic firstCanReceive, secondCanReceive, activeLevel, stableFault;
    logic [7:0] segIn, segOut, segOe, extDrive, waitCycles, latchedSeg;
    logic [7:0] doneAt, aleAt, aleCnt, rdCnt, wrCnt, segAtAle;
    logic [15:0] cfgExt;
    logic [3:0] wtab [4];
    int errTotal, checksDone, cycles;
    // resolved pin level, external side drives undriven lines
    assign segIn = (segOe & segOut) | (~segOe & extDrive);
    assign cfgExt = 16'h0001 << EBSP_CFG_EXTBUS;
    ebsp_top i_ebsp_top (.sys_clk(sys_clk), .reset(reset),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .accReq(accReq),
        .accWrite(accWrite), .accLowByte(accLowByte), .accAddr(accAddr),
        .accBusy(accBusy), .accDone(accDone), .segIn(segIn),
        .segOut(segOut), .segOe(segOe), .thresholdCmos(thresholdCmos),
        .readyPin(readyPin), .readStrobeN(readStrobeN),
        .lowByteStoreStrobeN(lowByteStoreStrobeN), .aleOut(aleOut),
        .firstCanTransmit(firstCanTransmit),
        .secondCanTransmit(secondCanTransmit),
        .firstCanReceive(firstCanReceive),
        .secondCanReceive(secondCanReceive));
    ebsp_mem_model i_ebsp_mem_model (.sys_clk(sys_clk), .reset(reset),
        .aleOut(aleOut), .readStrobeN(readStrobeN),
        .lowByteStoreStrobeN(lowByteStoreStrobeN), .segOut(segOut),
        .waitCycles(waitCycles), .activeLevel(activeLevel),
        .readyPin(readyPin), .latchedSeg(latchedSeg),
        .stableFault(stableFault));
    // ---------------------------------------------------------------
    // clock, timeout, tasks
    // ---------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            finalReport();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        v = regRdata;
    endtask
    task automatic acc(input logic w, input logic lowB,
                       input logic [23:0] a);
        int n;
        @(posedge sys_clk);
        accReq <= 1'b1;
        accWrite <= w;
        accLowByte <= lowB;
        accAddr <= a;
        @(posedge sys_clk);
        accReq <= 1'b0;
        {doneAt, aleAt, aleCnt, rdCnt, wrCnt} = '0;
        for (n = 1; n < 60 && doneAt == 8'h00; n++) begin
            #1;
            if (aleOut === 1'b1) begin
                aleCnt++;
                aleAt = 8'(n);
                segAtAle = segOut;
            end
            if (readStrobeN === 1'b0) rdCnt++;
            if (lowByteStoreStrobeN === 1'b0) wrCnt++;
            if (accDone === 1'b1) doneAt = 8'(n);
            else @(posedge sys_clk);
        end
    endtask
    task automatic canTest(input logic [15:0] cfg, input int rxl,
                           input int txl, input logic second);
        logic rxSeen;
        wr(EBSP_OFF_CFG, cfg);
        for (int v = 0; v < 2; v++) begin
            @(posedge sys_clk);
            extDrive[rxl] <= v[0];
            firstCanTransmit <= v[0] ^ second;
            secondCanTransmit <= v[0] ^ ~second;
            repeat (4) @(posedge sys_clk);
            #1;
            rxSeen = second ? secondCanReceive : firstCanReceive;
            chk8("can rx", {7'h00, v[0]}, {7'h00, rxSeen});
            chk8("can tx", {7'h00, v[0]}, {7'h00, segIn[txl]});
        end
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {regWrite, regRead, accReq, accWrite, accLowByte} = '0;
        {firstCanTransmit, secondCanTransmit, activeLevel} = 3'b111;
        {regAddr, regWdata, accAddr, errTotal, checksDone, cycles} = '0;
        reset = 1'b1;
        extDrive = 8'hFF;
        waitCycles = 8'h14;
        wtab = '{4'b0001, 4'b1000, 4'b1011, 4'b1101};
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk8("reset oe", 8'h00, segOe);
        chk8("reset strobes", 8'h03,
             {6'h00, readStrobeN, lowByteStoreStrobeN});
        wr(EBSP_OFF_DIR, 16'h00A5);
        rd(EBSP_OFF_DIR, d);
        chk("dir read", 16'h00A5, d);
        wr(EBSP_OFF_ODRAIN, 16'h00FF);
        rd(EBSP_OFF_ODRAIN, d);
        chk("odrain read", 16'h00F0, d);
        wr(4'h7, 16'h1234);
        rd(4'h7, d);
        chk("unmapped read", 16'h0000, d);
        wr(EBSP_OFF_ODRAIN, 16'h0000);
        wr(EBSP_OFF_DIR, 16'h000F);
        wr(EBSP_OFF_LATCH, 16'h005A);
        @(posedge sys_clk);
        extDrive <= 8'h3C;
        repeat (4) @(posedge sys_clk);
        #1;
        chk8("oe by dir", 8'h0F, segOe);
        chk8("driven value", 8'h0A, segOut & segOe);
        rd(EBSP_OFF_LATCH, d);
        chk("latch read", 16'h003A, d);
        rd(EBSP_OFF_STATUS, d);
        chk8("pin sample", 8'h3A, d[7:0]);
        wr(EBSP_OFF_CFG, 16'h0001 << EBSP_CFG_CMOS);
        repeat (2) @(posedge sys_clk);
        #1;
        chk8("cmos", 8'h01, {7'h00, thresholdCmos});
        wr(EBSP_OFF_CFG, 16'h0000);
        repeat (2) @(posedge sys_clk);
        #1;
        chk8("ttl", 8'h00, {7'h00, thresholdCmos});
        wr(EBSP_OFF_DIR, 16'h00FF);
        wr(EBSP_OFF_ODRAIN, 16'h00F0);
        wr(EBSP_OFF_LATCH, 16'h00F0);
        repeat (2) @(posedge sys_clk);
        #1;
        chk8("odrain high", 8'h0F, segOe);
        wr(EBSP_OFF_LATCH, 16'h000F);
        repeat (2) @(posedge sys_clk);
        #1;
        chk8("odrain low", 8'hFF, segOe);
        wr(EBSP_OFF_ODRAIN, 16'h0000);
        wr(EBSP_OFF_DIR, 16'h00C0);
        canTest(16'h0001 << EBSP_CFG_CAN1, 5, 6, 1'b0);
        canTest(16'h0001 << EBSP_CFG_CAN2, 4, 6, 1'b1);
        canTest(16'h0180, 5, 7, 1'b1);
        wr(EBSP_OFF_CFG, cfgExt);
        acc(1'b0, 1'b0, 24'hC3_1234);
        chk8("done cycle", 8'h03, doneAt);
        chk8("ale pulses", 8'h01, aleCnt);
        chk8("ale cycle", 8'h01, aleAt);
        chk8("segment addr", 8'hC3, segAtAle);
        chk8("captured addr", 8'hC3, latchedSeg);
        chk8("ext oe", 8'hFF, segOe);
        chk8("read strobes", 8'h01, rdCnt);
        chk8("store on read", 8'h00, wrCnt);
        chk8("busy in done", 8'h01, {7'h00, accBusy});
        for (int i = 0; i < 4; i++) begin
            wr(EBSP_OFF_CFG, cfgExt
                | ({15'h0000, wtab[i][3]} << EBSP_CFG_STYLE)
                | ({15'h0000, wtab[i][2]} << EBSP_CFG_BUS8));
            acc(1'b1, wtab[i][1], 24'h5A_0000);
            chk8("store strobes", {7'h00, wtab[i][0]},
                 wrCnt);
            chk8("read on write", 8'h00, rdCnt);
        end
        for (int p = 0; p < 2; p++) begin
            for (int w = 2; w <= 6; w += 4) begin
                wr(EBSP_OFF_CFG, cfgExt | (16'h0001 << EBSP_CFG_RDYEN)
                    | (16'(p) << EBSP_CFG_RDYPOL));
                @(posedge sys_clk);
                activeLevel <= p[0];
                waitCycles <= 8'(w);
                repeat (3) @(posedge sys_clk);
                acc(1'b0, 1'b0, 24'h81_0000);
                chk8("ready stretch", 8'h01,
                     8'(doneAt >= w + 3 && doneAt <= w + 7));
            end
        end
        chk8("addr stable", 8'h00, {7'h00, stableFault});
        finalReport();
    end
endmodule // ebsp_top_tb
`default_nettype wire
